// >>> include/exception_interrupt_control_consts.vh
// constants for the exception and interrupt control block
`ifndef EXCEPTION_INTERRUPT_CONTROL_CONSTS_VH
`define EXCEPTION_INTERRUPT_CONTROL_CONSTS_VH

// register byte offsets
`define OFS_EDGE_SEL_ONE 8'h00
`define OFS_EDGE_SEL_TWO 8'h04
`define OFS_PIN_FUNC_ONE 8'h08
`define OFS_PIN_FUNC_FIVE 8'h0c
`define OFS_INT_ENABLE 8'h10
`define OFS_REQ_FLAG 8'h14
`define OFS_WAKE_FLAG 8'h18
`define OFS_PERIPH_ENABLE 8'h1c
`define OFS_PERIPH_FLAG 8'h20
`define OFS_STATUS 8'h24

// field positions
`define POS_UNMASK_EDGE 7
`define POS_WAKE_ENABLE 5
`define WAKE_FLAG_RSVD 8'hc0

// reset values
`define RST_EDGE_SEL_ONE 8'h00
`define RST_EDGE_SEL_TWO 6'h00
`define RST_PIN_FUNC_ONE 4'h0
`define RST_PIN_FUNC_FIVE 6'h00

// timing
`define INIT_MIN_CYC 4'ha
`define RESET_VECTOR 16'h0000

// vector numbers, vector word address is twice the number
`define VEC_UNMASK 8'h07
`define VEC_ABRK 8'h08
`define VEC_EDGE_REQ0 8'h10
`define VEC_WAKEUP 8'h14
`define VEC_PERIPH0 8'h15

`endif

// >>> verilog/pin_edge_detect.v
// pin synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
	parameter W = 11
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] pins,
	input wire [W-1:0] rise_sel,
	output wire [W-1:0] edge_pulse
);
	reg [W-1:0] sync1_ff;
	reg [W-1:0] sync2_ff;
	reg [W-1:0] prev_ff;
	reg [1:0] primed_ff;

	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= {W{1'b1}};
			sync2_ff <= {W{1'b1}};
			prev_ff <= {W{1'b1}};
			primed_ff <= 2'b00;
		end else begin
			sync1_ff <= pins; // RULE24
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
			// quiet until both compare stages hold real pin samples
			if (primed_ff != 2'b11) begin
				primed_ff <= primed_ff + 2'b01;
			end
		end
	end

	// one pulse per qualifying edge, rise_sel high picks rising
	assign edge_pulse = {W{primed_ff == 2'b11}} &
		((rise_sel & sync2_ff & ~prev_ff) |
		(~rise_sel & ~sync2_ff & prev_ff)); // RULE24
endmodule // pin_edge_detect
`default_nettype wire

// >>> verilog/exception_interrupt_control.v
// reset and interrupt exception control with apb registers
//
// Design decisions made here: register access over APB and the register offsets.
`include "exception_interrupt_control_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: outside holds init pin low ten cycles
// RULE2: init low halts cpu, clears registers
// RULE3: init release starts reset sequence
// RULE4: reset sets mask, loads vector zero
// RULE5: unmaskable pin edge chosen by bit
// RULE6: unmaskable highest priority, ignores mask
// RULE7: four request pins, own vector, edge
// RULE8: enabled pin edge sets request flag
// RULE9: per pin enable masks request
// RULE10: six wakeup pins share one vector
// RULE11: wakeup edge sets flag, common enable
// RULE12: peripheral flag set, enable masks it
// RULE13: only enabled or unmaskable requests forwarded; abrk_req is forwarded with no enable bit
// RULE14: highest priority forwarded, others pending
// RULE15: mask bit gates all but unmaskable, break
// RULE16: accept at instruction end, stack pc, ccr
// RULE17: mask set after stacking, return restores
// RULE18: fetch source vector into pc
// RULE19: response fifteen to thirty-seven states
// RULE20: no interrupts before first instruction
// RULE21: word address low bit forced zero
// RULE22: software masks before pin function change
// RULE23: writing zero clears flag, one keeps
// RULE24: pins synchronised before edge detection
module exception_interrupt_control #(
	parameter N_PERIPH = 4
) (
	input wire clk,
	input wire rst_n,
	input wire hw_init_pin,
	input wire unmaskable_pin,
	input wire [3:0] edge_request_pins,
	input wire [5:0] wakeup_pins,
	input wire [N_PERIPH-1:0] periph_event,
	input wire abrk_req,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire cpu_insn_done,
	input wire cpu_i_bit,
	input wire [7:0] cpu_ccr,
	input wire [15:0] cpu_pc,
	input wire [15:0] cpu_sp,
	output wire cpu_halt,
	output reg pc_load,
	output reg [15:0] pc_value,
	output reg sp_load,
	output reg [15:0] sp_value,
	output reg ccr_i_set,
	output reg mem_req,
	output reg mem_we,
	output reg [15:0] mem_addr,
	output reg [15:0] mem_wdata,
	input wire mem_ack,
	input wire [15:0] mem_rdata
);
	localparam S_HOLD = 4'd0;
	localparam S_RST_MASK = 4'd1;
	localparam S_RST_VEC = 4'd2;
	localparam S_RUN = 4'd3;
	localparam S_PUSH_PC = 4'd4;
	localparam S_PUSH_CCR = 4'd5;
	localparam S_SET_MASK = 4'd6;
	localparam S_VEC = 4'd7;
	localparam NSRC = 7 + N_PERIPH;

	// word accesses never use an odd address
	function [15:0] word_addr;
		input [15:0] a;
		begin
			word_addr = {a[15:1], 1'b0}; // RULE21
		end
	endfunction

	function [15:0] vec_addr;
		input [7:0] num;
		begin
			vec_addr = word_addr({7'h00, num, 1'b0});
		end
	endfunction

	reg [3:0] state_ff;
	reg [3:0] init_cnt_ff;
	reg first_insn_ff;
	reg [7:0] edge_one_ff;
	reg [5:0] edge_two_ff;
	reg [3:0] pin_func_one_ff;
	reg [5:0] pin_func_five_ff;
	reg [3:0] req_en_ff;
	reg wake_en_ff;
	reg [3:0] req_flag_ff;
	reg [5:0] wake_flag_ff;
	reg [N_PERIPH-1:0] periph_en_ff;
	reg [N_PERIPH-1:0] periph_flag_ff;
	reg unmask_flag_ff;
	reg [7:0] vec_num_ff;
	reg [7:0] sel_vec;
	reg sel_valid;
	reg sel_unmask;
	reg [NSRC-1:0] req_vec;
	integer i;

	wire sreset = !rst_n || !hw_init_pin; // RULE2
	wire [10:0] pin_edges;
	wire wr_acc = psel && penable && pwrite;
	wire rd_setup = psel && !penable && !pwrite;
	wire mapped = (paddr <= `OFS_STATUS) && (paddr[1:0] == 2'b00);

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign cpu_halt = (state_ff != S_RUN); // RULE2

	pin_edge_detect #(
		.W(11)
	) u_edges (
		.clk(clk),
		.rst_n(!sreset),
		.pins({wakeup_pins, edge_request_pins, unmaskable_pin}),
		.rise_sel({edge_two_ff, edge_one_ff[3:0],
			edge_one_ff[`POS_UNMASK_EDGE]}), // RULE5 RULE7 RULE10
		.edge_pulse(pin_edges)
	);

	wire unmask_edge = pin_edges[0]; // RULE5
	wire [3:0] req_set = pin_edges[4:1] & pin_func_one_ff; // RULE8
	wire [5:0] wake_set = pin_edges[10:5] & pin_func_five_ff; // RULE11

	// write strobes per flag register
	wire wr_req_flag = wr_acc && (paddr == `OFS_REQ_FLAG);
	wire wr_wake_flag = wr_acc && (paddr == `OFS_WAKE_FLAG);
	wire wr_periph_flag = wr_acc && (paddr == `OFS_PERIPH_FLAG);

	// configuration registers
	always @(posedge clk) begin
		if (sreset) begin
			edge_one_ff <= `RST_EDGE_SEL_ONE;
			edge_two_ff <= `RST_EDGE_SEL_TWO;
			pin_func_one_ff <= `RST_PIN_FUNC_ONE;
			pin_func_five_ff <= `RST_PIN_FUNC_FIVE;
			req_en_ff <= 4'h0;
			wake_en_ff <= 1'b0;
			periph_en_ff <= {N_PERIPH{1'b0}};
		end else if (wr_acc) begin
			case (paddr)
				`OFS_EDGE_SEL_ONE: begin
					edge_one_ff <= {pwdata[7], 3'b000, pwdata[3:0]};
				end
				`OFS_EDGE_SEL_TWO: begin
					edge_two_ff <= pwdata[5:0];
				end
				`OFS_PIN_FUNC_ONE: begin
					pin_func_one_ff <= pwdata[3:0];
				end
				`OFS_PIN_FUNC_FIVE: begin
					pin_func_five_ff <= pwdata[5:0];
				end
				`OFS_INT_ENABLE: begin
					req_en_ff <= pwdata[3:0]; // RULE9
					wake_en_ff <= pwdata[`POS_WAKE_ENABLE]; // RULE11
				end
				`OFS_PERIPH_ENABLE: begin
					periph_en_ff <= pwdata[N_PERIPH-1:0]; // RULE12
				end
				default: begin
				end
			endcase
		end
	end

	// request flags, a set in the same cycle beats a clear
	always @(posedge clk) begin
		if (sreset) begin
			req_flag_ff <= 4'h0;
			wake_flag_ff <= 6'h00;
			periph_flag_ff <= {N_PERIPH{1'b0}};
		end else begin
			req_flag_ff <= (req_flag_ff &
				~({4{wr_req_flag}} & ~pwdata[3:0])) | req_set; // RULE23 RULE8
			wake_flag_ff <= (wake_flag_ff &
				~({6{wr_wake_flag}} & ~pwdata[5:0])) | wake_set; // RULE23 RULE11
			periph_flag_ff <= (periph_flag_ff &
				~({N_PERIPH{wr_periph_flag}} & ~pwdata[N_PERIPH-1:0])) |
				periph_event; // RULE12 RULE23
		end
	end

	// request vector in priority order, unmaskable first
	always @* begin
		req_vec = {NSRC{1'b0}};
		req_vec[0] = unmask_flag_ff; // RULE13
		req_vec[1] = abrk_req;
		req_vec[5:2] = req_flag_ff & req_en_ff; // RULE9 RULE13
		req_vec[6] = wake_en_ff && (wake_flag_ff != 6'h00); // RULE11 RULE13
		req_vec[NSRC-1:7] = periph_flag_ff & periph_en_ff; // RULE12 RULE13
	end

	// pick the highest one the mask bit lets through
	always @* begin
		sel_valid = 1'b0;
		sel_unmask = 1'b0;
		sel_vec = 8'h00;
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (req_vec[i] && (i < 2 || !cpu_i_bit)) begin // RULE15
				sel_valid = 1'b1; // RULE14
				sel_unmask = (i == 0); // RULE6
				if (i == 0) begin
					sel_vec = `VEC_UNMASK;
				end else if (i == 1) begin
					sel_vec = `VEC_ABRK;
				end else if (i < 6) begin
					sel_vec = `VEC_EDGE_REQ0 + i[7:0] - 8'd2; // RULE7
				end else if (i == 6) begin
					sel_vec = `VEC_WAKEUP; // RULE10
				end else begin
					sel_vec = `VEC_PERIPH0 + i[7:0] - 8'd7;
				end
			end
		end
	end

	wire accept = (state_ff == S_RUN) && cpu_insn_done && first_insn_ff &&
		sel_valid; // RULE16 RULE20

	// unmaskable flag, taken back by its own acceptance
	always @(posedge clk) begin
		if (sreset) begin
			unmask_flag_ff <= 1'b0;
		end else if (unmask_edge) begin
			unmask_flag_ff <= 1'b1; // RULE5
		end else if (accept && sel_unmask) begin
			unmask_flag_ff <= 1'b0; // RULE6
		end
	end

	// exception sequencer
	always @(posedge clk) begin
		if (sreset) begin
			state_ff <= S_HOLD;
			first_insn_ff <= 1'b0;
			vec_num_ff <= 8'h00;
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
			sp_load <= 1'b0;
			sp_value <= 16'h0000;
			ccr_i_set <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
			// count the low time from its first cycle, saturating
			if (!rst_n) begin
				init_cnt_ff <= `INIT_MIN_CYC;
			end else if (state_ff != S_HOLD) begin
				init_cnt_ff <= 4'h1; // RULE1
			end else if (init_cnt_ff != `INIT_MIN_CYC) begin
				init_cnt_ff <= init_cnt_ff + 4'h1; // RULE1
			end
		end else begin
			pc_load <= 1'b0;
			sp_load <= 1'b0;
			ccr_i_set <= 1'b0;
			if (cpu_insn_done && state_ff == S_RUN) begin
				first_insn_ff <= 1'b1; // RULE20
			end
			case (state_ff)
				S_HOLD: begin
					if (init_cnt_ff == `INIT_MIN_CYC) begin
						state_ff <= S_RST_MASK; // RULE3
					end else begin
						init_cnt_ff <= init_cnt_ff + 4'h1;
					end
				end
				S_RST_MASK: begin
					ccr_i_set <= 1'b1; // RULE4
					mem_req <= 1'b1;
					mem_we <= 1'b0;
					mem_addr <= word_addr(`RESET_VECTOR); // RULE4
					state_ff <= S_RST_VEC;
				end
				S_RST_VEC, S_VEC: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						pc_load <= 1'b1;
						pc_value <= mem_rdata; // RULE4 RULE18
						state_ff <= S_RUN;
					end
				end
				S_RUN: begin
					if (accept) begin
						vec_num_ff <= sel_vec;
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= word_addr(cpu_sp - 16'h0002); // RULE16
						mem_wdata <= cpu_pc; // RULE16
						state_ff <= S_PUSH_PC; // RULE19
					end
				end
				S_PUSH_PC: begin
					if (mem_ack) begin
						mem_addr <= word_addr(cpu_sp - 16'h0004); // RULE21
						mem_wdata <= {cpu_ccr, cpu_ccr}; // RULE16
						state_ff <= S_PUSH_CCR;
					end
				end
				S_PUSH_CCR: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						sp_load <= 1'b1;
						sp_value <= word_addr(cpu_sp - 16'h0004);
						state_ff <= S_SET_MASK;
					end
				end
				S_SET_MASK: begin
					ccr_i_set <= 1'b1; // RULE17
					mem_req <= 1'b1;
					mem_addr <= vec_addr(vec_num_ff); // RULE18
					state_ff <= S_VEC;
				end
				default: begin
					state_ff <= S_HOLD;
				end
			endcase
		end
	end

	// read data captured in the setup cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			case (paddr)
				`OFS_EDGE_SEL_ONE: prdata <= {24'h000000, edge_one_ff};
				`OFS_EDGE_SEL_TWO: prdata <= {26'h0000000, edge_two_ff};
				`OFS_PIN_FUNC_ONE: prdata <= {28'h0000000, pin_func_one_ff};
				`OFS_PIN_FUNC_FIVE: prdata <= {26'h0000000, pin_func_five_ff};
				`OFS_INT_ENABLE: begin
					prdata <= {26'h0000000, wake_en_ff, 1'b0, req_en_ff};
				end
				`OFS_REQ_FLAG: prdata <= {28'h0000000, req_flag_ff};
				`OFS_WAKE_FLAG: begin
					prdata <= {24'h000000, `WAKE_FLAG_RSVD | {2'b00, wake_flag_ff}};
				end
				`OFS_PERIPH_ENABLE: begin
					prdata <= {{(32-N_PERIPH){1'b0}}, periph_en_ff};
				end
				`OFS_PERIPH_FLAG: begin
					prdata <= {{(32-N_PERIPH){1'b0}}, periph_flag_ff};
				end
				`OFS_STATUS: begin
					prdata <= {22'h000000, unmask_flag_ff, first_insn_ff,
						vec_num_ff};
				end
				default: prdata <= 32'h00000000;
			endcase
		end
	end
	// RULE22: flags from a pin function change are left to software
endmodule // exception_interrupt_control
`default_nettype wire

// >>> sim/cpu_mem_model.sv
// cpu core and memory stand-in facing the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_halt,
	input wire logic ccr_i_set,
	input wire logic i_clr,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	output logic cpu_insn_done,
	output logic cpu_i_bit,
	output logic [7:0] cpu_ccr,
	output logic [15:0] cpu_pc,
	output logic [15:0] cpu_sp
);
	logic [2:0] cnt_ff;
	logic slow_ff;
	// odd stack pointer on purpose
	assign cpu_sp = 16'h0401;
	assign cpu_pc = 16'h0200;
	assign cpu_ccr = {cpu_i_bit, 7'h05};
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		cpu_insn_done <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!rst_n) begin
			cnt_ff <= 3'h0;
			slow_ff <= 1'b0;
			cpu_i_bit <= 1'b1;
			mem_rdata <= 16'h0;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
			if (ccr_i_set)
				cpu_i_bit <= 1'b1;
			else if (i_clr)
				cpu_i_bit <= 1'b0;
			if (!cpu_halt && cnt_ff == 3'h3)
				cpu_insn_done <= 1'b1;
			// prompt and stalled answers in turn
			if (mem_req && !mem_ack && (cnt_ff[0] || !slow_ff)) begin
				mem_ack <= 1'b1;
				slow_ff <= ~slow_ff;
				mem_rdata <= mem_addr ^ 16'h5a5a;
			end
		end
	end
endmodule // cpu_mem_model
`default_nettype wire

// >>> sim/eic_checker.sv
// assertions on the exception sequencer ports
`timescale 1ns/1ps
`default_nettype none
module eic_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hw_init_pin,
	input wire logic cpu_insn_done,
	input wire logic [7:0] cpu_ccr,
	input wire logic [15:0] cpu_pc,
	input wire logic [15:0] cpu_sp,
	input wire logic cpu_halt,
	input wire logic pc_load,
	input wire logic [15:0] pc_value,
	input wire logic sp_load,
	input wire logic [15:0] sp_value,
	input wire logic ccr_i_set,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence pc_push;
		$rose(mem_req) && mem_we;
	endsequence
	sequence pc_pushed;
		mem_req && mem_we && mem_ack && mem_wdata == cpu_pc;
	endsequence
	chk_reset_fetch: assert property ($rose(rst_n) |-> ##[1:3]
		(ccr_i_set && mem_req && !mem_we && mem_addr == 16'h0000))
		else $error("reset fetch");
	chk_pc_push: assert property (pc_push |-> $past(cpu_insn_done)
		&& mem_wdata == cpu_pc && mem_addr == ((cpu_sp - 16'h2) & 16'hfffe))
		else $error("pc push");
	chk_ccr_push: assert property (pc_pushed |=> mem_req && mem_we
		&& mem_wdata == {cpu_ccr, cpu_ccr}
		&& mem_addr == ((cpu_sp - 16'h4) & 16'hfffe)) else $error("ccr push");
	chk_mask_after: assert property (sp_load |=>
		ccr_i_set && mem_req && !mem_we) else $error("mask order");
	chk_vec_load: assert property (mem_req && !mem_we && mem_ack |=>
		pc_load && pc_value == $past(mem_rdata)) else $error("vector load");
	chk_run_resume: assert property (pc_load |-> ##[0:1] !cpu_halt)
		else $error("no resume");
	chk_halt_seq: assert property (mem_req |-> cpu_halt)
		else $error("cpu runs in sequence");
	chk_init_halt: assert property (!hw_init_pin |=> cpu_halt)
		else $error("init no halt");
	chk_sp_update: assert property (sp_load |->
		sp_value == ((cpu_sp - 16'h4) & 16'hfffe)) else $error("sp update");
	chk_resp_time: assert property (pc_push |-> ##[1:36] pc_load)
		else $error("slow response");
endmodule // eic_checker
bind exception_interrupt_control eic_checker i_eic_checker (.clk, .rst_n,
	.hw_init_pin, .cpu_insn_done, .cpu_ccr, .cpu_pc, .cpu_sp, .cpu_halt,
	.pc_load, .pc_value, .sp_load, .sp_value, .ccr_i_set, .mem_req, .mem_we,
	.mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
`default_nettype wire

// >>> sim/testbench.sv
// bench for the exception and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, hw_init_pin = 1'b1, i_clr = 1'b0;
	logic unmaskable_pin = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic abrk_req = 1'b0, err;
	logic [3:0] edge_request_pins = 4'hf, periph_event = 4'h0;
	logic [5:0] wakeup_pins = 6'h3f;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	wire logic pready, cpu_halt, pc_load, sp_load, ccr_i_set, mem_req;
	wire logic mem_we, mem_ack, cpu_insn_done, cpu_i_bit, pslverr;
	wire logic [31:0] prdata;
	wire logic [7:0] cpu_ccr;
	wire logic [15:0] pc_value, mem_addr, mem_wdata, mem_rdata, cpu_pc, cpu_sp;
	int fails = 0, n_compared = 0;
	always #25 clk = ~clk;
	exception_interrupt_control i_exception_interrupt_control (.clk,
		.rst_n, .hw_init_pin, .unmaskable_pin, .edge_request_pins,
		.wakeup_pins, .periph_event, .abrk_req, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.cpu_insn_done, .cpu_i_bit, .cpu_ccr, .cpu_pc, .cpu_sp, .cpu_halt,
		.pc_load, .pc_value, .sp_load, .sp_value(), .ccr_i_set, .mem_req,
		.mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	cpu_mem_model i_cpu_mem_model (.clk, .rst_n, .cpu_halt, .ccr_i_set,
		.i_clr, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .cpu_insn_done,
		.cpu_i_bit, .cpu_ccr, .cpu_pc, .cpu_sp);
	task results;
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input [7:0] a, input [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task clr_i;
		@(posedge clk) i_clr <= 1'b1;
		@(posedge clk) i_clr <= 1'b0;
	endtask
	// waits for the handler start, memory holds addr xor 5a5a
	task vec(input [15:0] va);
		int k;
		k = 0;
		@(negedge clk);
		while (pc_load !== 1'b1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		chk({pc_load, pc_value}, {1'b1, va ^ 16'h5a5a});
	endtask
	task none;
		logic s;
		s = 1'b0;
		repeat (60) @(negedge clk) s = s | pc_load;
		chk(s, 1'b0);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		vec(16'h0000);
		rdc(8'h18, 32'hc0);
		apb(1'b1, 8'h08, 32'hf);
		apb(1'b1, 8'h0c, 32'h3f);
		apb(1'b1, 8'h14, 32'h0);
		clr_i;
		@(posedge clk) edge_request_pins[2] <= 1'b0;
		none;
		rdc(8'h14, 32'h4);
		apb(1'b1, 8'h14, 32'hf);
		rdc(8'h14, 32'h4);
		@(posedge clk) wakeup_pins[0] <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(8'h18, 32'hc1);
		apb(1'b1, 8'h10, 32'h2f);
		vec(16'h0024);
		apb(1'b1, 8'h14, 32'h0);
		clr_i;
		vec(16'h0028);
		apb(1'b1, 8'h18, 32'h0);
		apb(1'b1, 8'h1c, 32'h1);
		@(posedge clk) periph_event[0] <= 1'b1;
		@(posedge clk) periph_event[0] <= 1'b0;
		none;
		rdc(8'h20, 32'h1);
		clr_i;
		vec(16'h002a);
		apb(1'b1, 8'h20, 32'h0);
		@(posedge clk) edge_request_pins[2] <= 1'b1;
		for (int n = 0; n < 4; n++) begin
			clr_i;
			@(posedge clk) edge_request_pins[n] <= 1'b0;
			vec(16'h0020 + 16'(2 * n));
			@(posedge clk) edge_request_pins[n] <= 1'b1;
			apb(1'b1, 8'h14, 32'h0);
		end
		apb(1'b1, 8'h00, 32'h80);
		@(posedge clk) unmaskable_pin <= 1'b0;
		none;
		@(posedge clk) unmaskable_pin <= 1'b1;
		vec(16'h000e);
		@(posedge clk) abrk_req <= 1'b1;
		vec(16'h0010);
		@(posedge clk) abrk_req <= 1'b0;
		@(posedge clk) hw_init_pin <= 1'b0;
		repeat (10) @(posedge clk);
		hw_init_pin <= 1'b1;
		vec(16'h0000);
		rdc(8'h00, 32'h0);
		rdc(8'h28, 32'h0);
		chk(err, 1'b1);
		results;
	end
	initial begin
		#1000000;
		fails++;
		results;
	end
endmodule // testbench
`default_nettype wire
